// *** hdl/sadc_pkg.sv ***
// package: register map, field layout and timing of the converter control block
package sadc_pkg;
    // register byte offsets (printed offsets are not all multiples of four: index * 4)
    localparam logic [7:0]  IDX_AUX_CONTROL    = 8'hE1;
    localparam logic [7:0]  IDX_RESULT_HIGH    = 8'hE2;
    localparam logic [7:0]  IDX_CONTROL_STATUS = 8'hF8;
    localparam logic [7:0]  IDX_IRQ_STATUS     = 8'hF9;
    localparam logic [7:0]  IDX_IRQ_ENABLE     = 8'hFA;
    localparam logic [7:0]  IDX_IRQ_CLEAR      = 8'hFB;
    localparam logic [9:0]  ADDR_AUX_CONTROL    = {IDX_AUX_CONTROL, 2'b00};
    localparam logic [9:0]  ADDR_RESULT_HIGH    = {IDX_RESULT_HIGH, 2'b00};
    localparam logic [9:0]  ADDR_CONTROL_STATUS = {IDX_CONTROL_STATUS, 2'b00};
    localparam logic [9:0]  ADDR_IRQ_STATUS     = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [9:0]  ADDR_IRQ_ENABLE     = {IDX_IRQ_ENABLE, 2'b00};
    localparam logic [9:0]  ADDR_IRQ_CLEAR      = {IDX_IRQ_CLEAR, 2'b00};
    // control/status field positions
    localparam int          F_RES1   = 7;
    localparam int          F_RES0   = 6;
    localparam int          F_EXTEN  = 5;
    localparam int          F_DONE   = 4;
    localparam int          F_START  = 3;
    // aux control field positions
    localparam int          F_CONV_EN  = 7;
    localparam int          F_CLK_SEL  = 1;
    localparam int          F_SRC_SEL  = 0;
    localparam logic [7:0]  AUX_MASK   = 8'h83;
    // reset values
    localparam logic [7:0]  RST_AUX    = 8'h00;
    localparam logic [7:0]  RST_CTRL   = 8'h00;
    localparam logic [9:0]  RST_RESULT = 10'h000;
    // timing: machine cycle and conversion length
    localparam int          MACHINE_CYCLE_NS = 4;
    localparam int          CLK_PERIOD_NS    = 4;
    localparam int          MC_CLKS          = (MACHINE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CONV_MCYCLES     = 35;
    localparam int          SYS_CLK_DIV      = 4;
    localparam int          RC_CLK_DIV       = 2;
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'b10;

    typedef struct packed {
        logic       conv_en;
        logic       clk_sel;
        logic       src_sel;
    } sadc_aux_t;

    typedef struct packed {
        logic [2:0] chan;
        logic       src_bandgap;
        logic       enable;
        logic       sample;
        logic       clk_div;
    } sadc_core_t;
endpackage : sadc_pkg

// *** hdl/sadc_ctrl.sv ***
// converter control: start/busy/done handshake, channel mux, result split, AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl
#(
    parameter int CONV_CYCLES = sadc_pkg::CONV_MCYCLES * sadc_pkg::MC_CLKS
)
(
    // clock and reset
    input  wire  logic                 ref_clk_i,
    input  wire  logic                 sys_rst_i,
    // AHB-Lite slave
    input  wire  logic                 hsel_i,
    input  wire  logic [31:0]          haddr_i,
    input  wire  logic [1:0]           htrans_i,
    input  wire  logic                 hwrite_i,
    input  wire  logic [2:0]           hsize_i,
    input  wire  logic [31:0]          hwdata_i,
    input  wire  logic                 hready_i,
    output var   logic [31:0]          hrdata_o,
    output var   logic                 hreadyout_o,
    output var   logic                 hresp_o,
    // pins and power state
    input  wire  logic                 external_start_pin_i,
    input  wire  logic                 low_power_i,
    input  wire  logic                 rc_osc_tick_i,
    // converter core
    input  wire  logic                 comp_result_i,
    input  wire  logic [9:0]           core_result_i,
    output var   sadc_pkg::sadc_core_t core_o,
    output var   logic                 adc_clk_en_o,
    // interrupt
    output var   logic                 irq_o
);
    import sadc_pkg::*;

    localparam int CW = $clog2(CONV_CYCLES + 1);

    typedef enum {ST_IDLE, ST_CONV} sadc_state_t;

    sadc_state_t state_reg, state_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [7:0]  ctrl_reg, ctrl_next;
    logic [7:0]  aux_reg, aux_next;
    logic [7:0]  resh_reg, resh_next;
    logic        irq_st_reg, irq_st_next;
    logic        irq_en_reg, irq_en_next;
    logic        pin_q_reg, pin_q_next;
    logic        wr_pend_reg, wr_pend_next;
    logic [9:0]  wr_addr_reg, wr_addr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        irq_reg, irq_next;
    logic [1:0]  div_reg, div_next;
    logic        clk_en_reg, clk_en_next;
    sadc_core_t  core_reg, core_next;

    logic        addr_ok, wr_ctrl, wr_aux, wr_resh, wr_ien, wr_iclr;
    logic [7:0]  wb;
    logic        pin_rise, sw_start, done_evt, abort;

    assign addr_ok = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
    assign wb      = hwdata_i[7:0];
    assign wr_ctrl = wr_pend_reg && wr_addr_reg == ADDR_CONTROL_STATUS;
    assign wr_aux  = wr_pend_reg && wr_addr_reg == ADDR_AUX_CONTROL;
    assign wr_resh = wr_pend_reg && wr_addr_reg == ADDR_RESULT_HIGH;
    assign wr_ien  = wr_pend_reg && wr_addr_reg == ADDR_IRQ_ENABLE;
    assign wr_iclr = wr_pend_reg && wr_addr_reg == ADDR_IRQ_CLEAR;

    // machine cycle equals one clock here, so the edge is seen every clock
    assign pin_rise = ctrl_reg[F_EXTEN] && external_start_pin_i && !pin_q_reg;
    assign sw_start = wr_ctrl && wb[F_START];
    assign done_evt = state_reg == ST_CONV && cnt_reg == CW'(CONV_CYCLES - 1);
    // software abort or power-down stop the conversion; done result untouched
    assign abort    = state_reg == ST_CONV
                      && ((wr_ctrl && !wb[F_START]) || low_power_i);

    always_comb
    begin
        logic done_now;
        logic start_ok;
        done_now     = ctrl_reg[F_DONE];
        start_ok     = 1'b0;
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        ctrl_next    = ctrl_reg;
        aux_next     = aux_reg;
        resh_next    = resh_reg;
        irq_st_next  = irq_st_reg;
        irq_en_next  = irq_en_reg;
        pin_q_next   = external_start_pin_i;
        wr_pend_next = addr_ok && hwrite_i;
        wr_addr_next = addr_ok ? haddr_i[9:0] : wr_addr_reg;
        rdata_next   = 32'h0000_0000;
        if (wr_aux)
            aux_next = wb & AUX_MASK;
        if (wr_resh)
            resh_next = wb;
        if (wr_ien)
            irq_en_next = wb[0];
        if (wr_ctrl)
        begin
            ctrl_next[F_EXTEN] = wb[F_EXTEN];
            ctrl_next[F_RES1]  = wb[F_RES1];
            ctrl_next[F_RES0]  = wb[F_RES0];
            if (!wb[F_DONE])
                ctrl_next[F_DONE] = 1'b0;
            done_now = ctrl_next[F_DONE];
            if (!ctrl_reg[F_DONE] && !ctrl_reg[F_START])
                ctrl_next[2:0] = wb[2:0];
        end
        // clearing done and setting start together is allowed to start
        start_ok = state_reg == ST_IDLE && !done_now && aux_reg[F_CONV_EN];
        if (state_reg == ST_IDLE)
        begin
            if (start_ok && (sw_start || pin_rise) && !low_power_i)
            begin
                state_next         = ST_CONV;
                cnt_next           = '0;
                ctrl_next[F_START] = 1'b1;
            end
        end
        else if (abort || !aux_reg[F_CONV_EN])
        begin
            state_next         = ST_IDLE;
            ctrl_next[F_START] = 1'b0;
        end
        else if (done_evt)
        begin
            state_next         = ST_IDLE;
            ctrl_next[F_START] = 1'b0;
            ctrl_next[F_DONE]  = 1'b1;
            ctrl_next[F_RES1]  = core_result_i[1];
            ctrl_next[F_RES0]  = core_result_i[0];
            resh_next          = core_result_i[9:2];
        end
        else
        begin
            cnt_next = cnt_reg + CW'(1);
        end
        // set wins over clear for the sticky interrupt flag
        if (wr_iclr && wb[0])
            irq_st_next = 1'b0;
        if (done_evt && !abort && aux_reg[F_CONV_EN])
            irq_st_next = 1'b1;
        if (addr_ok && !hwrite_i)
        begin
            case (haddr_i[9:0])
                ADDR_CONTROL_STATUS: rdata_next = {24'h00_0000, ctrl_reg};
                ADDR_AUX_CONTROL:    rdata_next = {24'h00_0000, aux_reg};
                ADDR_RESULT_HIGH:    rdata_next = {24'h00_0000, resh_reg};
                ADDR_IRQ_STATUS:     rdata_next = {31'h0000_0000, irq_st_reg};
                ADDR_IRQ_ENABLE:     rdata_next = {31'h0000_0000, irq_en_reg};
                default:             rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_comb
    begin
        irq_next = irq_st_next && irq_en_next;
        div_next = div_reg + 2'h1;
        if (aux_reg[F_CLK_SEL])
            clk_en_next = rc_osc_tick_i && div_reg[0];
        else
            clk_en_next = div_reg == 2'(SYS_CLK_DIV - 1);
        if (!aux_reg[F_CLK_SEL] && div_reg == 2'(SYS_CLK_DIV - 1))
            div_next = 2'h0;
        if (aux_reg[F_CLK_SEL] && !rc_osc_tick_i)
            div_next = div_reg;
        core_next.chan        = ctrl_next[2:0];
        core_next.src_bandgap = aux_next[F_SRC_SEL];
        core_next.enable      = aux_next[F_CONV_EN];
        core_next.sample      = state_next == ST_CONV;
        core_next.clk_div     = aux_next[F_CLK_SEL];
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            state_reg   <= ST_IDLE;
            cnt_reg     <= '0;
            ctrl_reg    <= RST_CTRL;
            aux_reg     <= RST_AUX;
            resh_reg    <= RST_RESULT[9:2];
            irq_st_reg  <= 1'b0;
            irq_en_reg  <= 1'b0;
            // held high so a pin already high at reset is not taken as an edge
            pin_q_reg   <= 1'b1;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 10'h000;
            rdata_reg   <= 32'h0000_0000;
            irq_reg     <= 1'b0;
            div_reg     <= 2'h0;
            clk_en_reg  <= 1'b0;
            core_reg    <= '0;
        end
        else
        begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            ctrl_reg    <= ctrl_next;
            aux_reg     <= aux_next;
            resh_reg    <= resh_next;
            irq_st_reg  <= irq_st_next;
            irq_en_reg  <= irq_en_next;
            pin_q_reg   <= pin_q_next;
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            rdata_reg   <= rdata_next;
            irq_reg     <= irq_next;
            div_reg     <= div_next;
            clk_en_reg  <= clk_en_next;
            core_reg    <= core_next;
        end
    end

    assign hrdata_o    = rdata_reg;
    // no wait states: every register answers in its data phase
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign irq_o       = irq_reg;
    assign core_o      = core_reg;
    assign adc_clk_en_o = clk_en_reg;

    // assertions
    sequence s_started;
        state_reg == ST_IDLE ##1 state_reg == ST_CONV;
    endsequence
    // last count of an uninterrupted conversion
    sequence s_last_count;
        done_evt && !abort && aux_reg[F_CONV_EN];
    endsequence

    a_conv_length: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(ctrl_reg[F_DONE]) |-> $past(ctrl_reg[F_START], CONV_CYCLES)
        && !$past(ctrl_reg[F_START], CONV_CYCLES + 1)) else $error("conversion length wrong");
    a_busy_on_start: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        s_started |-> ctrl_reg[F_START] && !ctrl_reg[F_DONE])
        else $error("busy not shown at start");
    a_done_clears_busy: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(ctrl_reg[F_DONE]) |-> !ctrl_reg[F_START]) else $error("busy high with done");
    a_no_start_done: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(ctrl_reg[F_START]) |-> !ctrl_reg[F_DONE]) else $error("start while done");
    a_done_blocks: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (state_reg == ST_IDLE && ctrl_reg[F_DONE] && !(wr_ctrl && !wb[F_DONE]))
        |=> state_reg == ST_IDLE) else $error("start while done flag high");
    a_ext_ignored: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (state_reg == ST_IDLE && !ctrl_reg[F_EXTEN] && !wr_ctrl) |=> state_reg == ST_IDLE)
        else $error("start without request");
    a_abort_sw: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (state_reg == ST_CONV && wr_ctrl && !wb[F_START]) |=> !ctrl_reg[F_START]
        && !ctrl_reg[F_DONE]) else $error("abort failed");
    a_chan_locked: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (ctrl_reg[F_START] || ctrl_reg[F_DONE]) |=> $stable(ctrl_reg[2:0]))
        else $error("channel changed while busy");
    a_result_with_done: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        done_evt && !abort && aux_reg[F_CONV_EN] |=> resh_reg == $past(core_result_i[9:2])
        && ctrl_reg[F_RES1:F_RES0] == $past(core_result_i[1:0])) else $error("result split");
    a_irq_level: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        irq_o == (irq_st_reg && irq_en_reg)) else $error("irq mismatch");
    a_disabled_idle: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        !aux_reg[F_CONV_EN] |=> state_reg == ST_IDLE) else $error("ran while disabled");
    a_done_sw: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (!ctrl_reg[F_DONE] && !done_evt) |=> !ctrl_reg[F_DONE]) else $error("done set by write");
    a_done_sets_irq: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        s_last_count |=> ctrl_reg[F_DONE] && irq_st_reg && !ctrl_reg[F_START])
        else $error("finish not flagged");
    a_ext_start: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (state_reg == ST_IDLE && ctrl_reg[F_EXTEN] && !ctrl_reg[F_DONE] && aux_reg[F_CONV_EN]
        && !low_power_i && external_start_pin_i && !pin_q_reg) |=> state_reg == ST_CONV)
        else $error("pin edge did not start");
    a_power_abort: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (state_reg == ST_CONV && low_power_i) |=> state_reg == ST_IDLE && !ctrl_reg[F_START])
        else $error("power-down did not abort");
    a_result_kept: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (ctrl_reg[F_DONE] && low_power_i && !wr_ctrl && !wr_resh) |=> ctrl_reg[F_DONE]
        && $stable(resh_reg)) else $error("result lost in power-down");
    // routing checks: the core sees the current register fields
    a_chan_route: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        core_o.chan == ctrl_reg[2:0]) else $error("channel route wrong");
    a_src_route: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        core_o.src_bandgap == aux_reg[F_SRC_SEL]) else $error("source route wrong");
    a_enable_route: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        core_o.enable == aux_reg[F_CONV_EN]) else $error("enable route wrong");
endmodule : sadc_ctrl
`default_nettype wire

// *** tb/sadc_core_model.sv ***
// analog core stand-in: gives a result code for the selected input
`timescale 1ns/1ps
`default_nettype none
module sadc_core_model
(
    input  wire logic                 ref_clk_i,
    input  wire sadc_pkg::sadc_core_t core_i,
    output var  logic [9:0]           result_o
);
    import sadc_pkg::*;
    // disabled core shows a moving pattern, never a stale code
    always_ff @(posedge ref_clk_i)
    begin
        if (!core_i.enable)
            result_o <= ~result_o;
        else if (core_i.src_bandgap)
            result_o <= 10'h2A5;
        else
            result_o <= {core_i.chan, 4'h6, ~core_i.chan};
    end
endmodule : sadc_core_model
`default_nettype wire

// *** tb/sar_adc_control_test.sv ***
// bench: register access, conversions, pin start, abort, power-down, interrupt
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_test;
    import sadc_pkg::*;
    localparam logic [9:0] CS = ADDR_CONTROL_STATUS;
    localparam logic [9:0] RH = ADDR_RESULT_HIGH;
    logic        clk, rst, hsel, hwrite, hready, hresp, pin, lp, rc, clk_en, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [9:0]  res;
    logic [7:0]  d;
    sadc_core_t  core;
    int          n_errors, num_checks, ne, rcn;
    // rows: clock select, source select, channel, expected result
    logic [14:0] rows [8] = '{15'h0037, 15'h04B6, 15'h4935, 15'h4DB4,
                              15'h1233, 15'h36A5, 15'h5B31, 15'h5FB0};
    logic [9:0]  regs [5] = '{ADDR_AUX_CONTROL, RH, CS, ADDR_IRQ_STATUS, 10'h000};

    sadc_ctrl #(.CONV_CYCLES(35)) dut (
        .ref_clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .external_start_pin_i(pin), .low_power_i(lp), .rc_osc_tick_i(rc),
        .comp_result_i(res[0]), .core_result_i(res), .core_o(core),
        .adc_clk_en_o(clk_en), .irq_o(irq));
    sadc_core_model model (.ref_clk_i(clk), .core_i(core), .result_o(res));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // oscillator tick every six clocks
    always @(posedge clk)
    begin
        rcn <= (rcn + 1) % 6;
        rc <= (rcn == 0);
    end

    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    // one AHB-Lite single transfer; read byte lands in d
    task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {22'h0, a};
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge clk); while (hready !== 1'b1);
        d = hrdata[7:0];
    endtask : xfer

    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt

    task automatic st(input logic [1:0] e);
        xfer(1'b0, CS, 8'h00);
        chk(d[4:3], e);
    endtask : st

    task automatic pulse;
        @(posedge clk);
        pin <= 1'b1;
        repeat (3) @(posedge clk);
        pin <= 1'b0;
    endtask : pulse

    initial
    begin
        {hsel, hwrite, pin, lp, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        n_errors = 0;
        num_checks = 0;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        foreach (regs[k])
        begin
            xfer(1'b0, regs[k], 8'h00);
            chk(d, 8'h00);
            chk(hresp, 1'b0);
        end
        xfer(1'b1, ADDR_IRQ_ENABLE, 8'h01);
        $display("reset values done");
        for (int i = 0; i < 8; i++)
        begin
            xfer(1'b1, ADDR_AUX_CONTROL, {6'h20, rows[i][14:13]});
            xfer(1'b1, CS, {5'h00, rows[i][12:10]});
            xfer(1'b1, CS, {5'h01, rows[i][12:10]});
            ne = 0;
            repeat (24)
            begin
                @(negedge clk);
                ne += clk_en;
            end
            chk(10'(ne), rows[i][14] ? 10'h002 : 10'h006);
            chk(core.clk_div, rows[i][14]);
            chk(core.sample, 1'b1);
            chk(core.chan, rows[i][12:10]);
            chk(core.src_bandgap, rows[i][13]);
            chk(core.enable, 1'b1);
            st(2'b01);
            wt(12);
            st(2'b10);
            chk(d[7:6], rows[i][1:0]);
            chk(irq, 1'b1);
            xfer(1'b0, RH, 8'h00);
            chk(d, rows[i][9:2]);
            xfer(1'b1, CS, {5'h00, rows[i][12:10]});
            xfer(1'b1, ADDR_IRQ_CLEAR, 8'h01);
            wt(2);
            chk(irq, 1'b0);
            $display("row %0d done", i);
        end
        xfer(1'b1, ADDR_AUX_CONTROL, 8'h80);
        xfer(1'b1, CS, 8'h02);
        xfer(1'b1, CS, 8'h0A);
        xfer(1'b1, CS, 8'h0D);
        chk(core.chan, 3'h2);
        st(2'b01);
        xfer(1'b1, CS, 8'h02);
        st(2'b00);
        wt(40);
        st(2'b00);
        chk(core.sample, 1'b0);
        $display("abort done");
        pulse();
        st(2'b00);
        xfer(1'b1, ADDR_IRQ_ENABLE, 8'h00);
        xfer(1'b1, CS, 8'h22);
        pulse();
        st(2'b01);
        wt(40);
        st(2'b10);
        chk(irq, 1'b0);
        xfer(1'b0, ADDR_IRQ_STATUS, 8'h00);
        chk(d[0], 1'b1);
        xfer(1'b1, ADDR_IRQ_ENABLE, 8'h01);
        wt(2);
        chk(irq, 1'b1);
        $display("pin start done");
        xfer(1'b1, CS, 8'h3A);
        st(2'b10);
        pulse();
        st(2'b10);
        lp <= 1'b1;
        wt(4);
        xfer(1'b0, RH, 8'h00);
        chk(d, rows[2][9:2]);
        st(2'b10);
        lp <= 1'b0;
        xfer(1'b1, CS, 8'h0A);
        st(2'b01);
        xfer(1'b1, CS, 8'h02);
        xfer(1'b1, CS, 8'h12);
        st(2'b00);
        $display("refusals done");
        xfer(1'b1, CS, 8'h0A);
        repeat (5) @(posedge clk);
        lp <= 1'b1;
        repeat (3) @(posedge clk);
        lp <= 1'b0;
        st(2'b00);
        chk(core.sample, 1'b0);
        wt(40);
        st(2'b00);
        $display("power-down done");
        xfer(1'b1, CS, 8'h0A);
        st(2'b01);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        chk(core.enable, 1'b0);
        chk(irq, 1'b0);
        xfer(1'b0, CS, 8'h00);
        chk(d, 8'h00);
        xfer(1'b0, ADDR_AUX_CONTROL, 8'h00);
        chk(d, 8'h00);
        $display("mid-run reset done");
        test_done();
    end

    initial
    begin
        #100000;
        n_errors++;
        test_done();
    end
endmodule : sar_adc_control_test
`default_nettype wire
